// File: hw/dcc_channel_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bit7 read-only; bits 2,1 read zero
// - tc flag sets at end, read clears
// - chain-keep set keeps enable at end
// - chain-keep: hardware request ignores tc flag
// - chain-keep: soft trigger needs tc cleared
// - no chain-keep: enable cleared at end
// - abort write terminates running transfer
// - soft trigger needs enable=1, tc=0
// - enable clears on end (no chain-keep), abort, nmi
// - nmi captures four enables into snapshot
// - snapshot is read-only, whole byte
// - restart bits set channel enables
// - tc select merges counts onto one pin
// - four channels, byte access registers
module dcc_channel_ctrl
    import dcc_pkg::*;
#(
    parameter int N = NUM_CH
) (
    input  wire logic              i_clock,        // system clock
    input  wire logic              i_rst_n,        // sync reset, active low
    input  wire logic [ADDR_W-1:0] i_addr,         // register address
    input  wire logic [DATA_W-1:0] i_wdata,        // write data
    input  wire logic              i_wr,           // write strobe
    input  wire logic              i_rd,           // read strobe
    output logic      [DATA_W-1:0] o_rdata,        // read data, next cycle
    input  wire logic [1:0]        i_external_request_pin, // request pins
    input  wire logic [N-1:0]      i_periph_req,   // peripheral interrupt requests
    input  wire logic [N-1:0]      i_pin_sel,      // channel n uses pin (else periph)
    input  wire logic              i_nmi,          // nmi pin
    input  wire logic [N-1:0]      i_xfer_done,    // transfer engine end pulse
    output logic      [N-1:0]      o_xfer_start,   // start pulse to engine
    output logic      [N-1:0]      o_xfer_abort,   // abort pulse to engine
    output logic      [N-1:0]      o_busy,         // channel transferring
    output logic                   o_combined_terminal_count_out_n // merged tc, low
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // bit 2 carries the nmi pin, bits 1:0 the request pins
    logic [2:0] sync1_q;
    logic [2:0] sync1_d;
    logic [2:0] sync2_q;
    logic [2:0] sync2_d;
    logic       nmi_prev_q;
    logic       nmi_prev_d;
    logic       nmi_evt;

    always_comb begin
        sync1_d    = {i_nmi, i_external_request_pin};
        sync2_d    = sync1_q;
        nmi_prev_d = sync2_q[2];
    end

    // two flops before any logic sees a pin
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            nmi_prev_q <= 1'b0;
        end else begin
            sync1_q    <= sync1_d;
            sync2_q    <= sync2_d;
            nmi_prev_q <= nmi_prev_d;
        end
    end

    // only the rising edge counts, so a held nmi stops channels once
    assign nmi_evt = sync2_q[2] & ~nmi_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    // control register address of channel ch
    function automatic logic [ADDR_W-1:0] ctrl_addr(input int ch);
        unique case (ch)
            0:       ctrl_addr = ADDR_CTRL_0;
            1:       ctrl_addr = ADDR_CTRL_1;
            2:       ctrl_addr = ADDR_CTRL_2;
            default: ctrl_addr = ADDR_CTRL_3;
        endcase
    endfunction : ctrl_addr

    // full address compare, so no register shows up at an alias
    logic [N-1:0] wr_ctrl;
    logic [N-1:0] rd_ctrl;
    logic         wr_restart;
    logic         wr_tc_sel;

    always_comb begin
        for (int c = 0; c < N; c++) begin
            wr_ctrl[c] = i_wr && (i_addr == ctrl_addr(c));
            rd_ctrl[c] = i_rd && (i_addr == ctrl_addr(c));
        end
        wr_restart = i_wr && (i_addr == ADDR_RESTART);
        wr_tc_sel  = i_wr && (i_addr == ADDR_TC_SEL);
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel state
    // channel c listens to request pin c modulo the pin count
    localparam int PIN_CNT = $bits(i_external_request_pin);

    logic [N-1:0] en_q;
    logic [N-1:0] en_d;
    logic [N-1:0] keep_q;
    logic [N-1:0] keep_d;
    logic [N-1:0] tc_q;
    logic [N-1:0] tc_d;
    logic [N-1:0] busy_q;
    logic [N-1:0] busy_d;

    logic [N-1:0] start_q;
    logic [N-1:0] start_d;
    logic [N-1:0] abort_q;
    logic [N-1:0] abort_d;
    logic [N-1:0] tcp_q;
    logic [N-1:0] tcp_d;

    logic [N-1:0] snap_q;
    logic [N-1:0] snap_d;
    logic [N-1:0] sel_q;
    logic [N-1:0] sel_d;

    logic [N-1:0] hw_req;
    logic [N-1:0] soft_trig;
    logic [N-1:0] kill;

    // request source per channel, and the write-side triggers
    always_comb begin
        for (int c = 0; c < N; c++) begin
            if (i_pin_sel[c]) begin
                hw_req[c] = sync2_q[c % PIN_CNT];
            end else begin
                hw_req[c] = i_periph_req[c];
            end
            // a soft trigger is refused while the tc flag is still set
            soft_trig[c] = wr_ctrl[c] && i_wdata[BIT_TRIG] && !tc_q[c];
            kill[c]      = (wr_ctrl[c] && i_wdata[BIT_ABORT]) || nmi_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // nmi snapshot and tc output select
    always_comb begin
        snap_d = snap_q;
        sel_d  = sel_q;
        if (wr_tc_sel) begin
            sel_d = i_wdata[N-1:0];
        end
        if (nmi_evt) begin
            // enables as they stood before this cycle's nmi clears them
            snap_d = en_q;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            snap_q <= '0;
            sel_q  <= '0;
        end else begin
            snap_q <= snap_d;
            sel_q  <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel enable, tc flag and transfer state
    always_comb begin
        en_d    = en_q;
        keep_d  = keep_q;
        tc_d    = tc_q;
        busy_d  = busy_q;
        // pulses default low and last one cycle
        start_d = '0;
        abort_d = '0;
        tcp_d   = '0;

        for (int c = 0; c < N; c++) begin
            // reading the control register clears tc
            if (rd_ctrl[c]) begin
                tc_d[c] = 1'b0;
            end
            // a control write sets keep and enable directly
            if (wr_ctrl[c]) begin
                keep_d[c] = i_wdata[BIT_KEEP];
                en_d[c]   = i_wdata[BIT_EN];
            end

            // writing zero to a restart bit leaves the enable alone
            if (wr_restart && i_wdata[c]) begin
                en_d[c] = 1'b1;
            end

            // a done sets tc even when a read clears it in the same cycle
            if (busy_q[c] && i_xfer_done[c]) begin
                busy_d[c] = 1'b0;
                tc_d[c]   = 1'b1;
                tcp_d[c]  = 1'b1;
                // chain-keep holds the enable for the next hardware request
                if (!keep_q[c]) begin
                    en_d[c] = 1'b0;
                end
            end else if (!busy_q[c] && en_q[c]) begin
                // the registered enable counts, so enable before triggering
                if (hw_req[c] || soft_trig[c]) begin
                    busy_d[c]  = 1'b1;
                    start_d[c] = 1'b1;
                end
            end

            // abort and nmi come last so they win over start and the enable, but a same-cycle done still sets tc
            if (kill[c]) begin
                busy_d[c]  = 1'b0;
                start_d[c] = 1'b0;
                abort_d[c] = busy_q[c];
                en_d[c]    = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            en_q    <= '0;
            keep_q  <= '0;
            tc_q    <= '0;
            busy_q  <= '0;
            start_q <= '0;
            abort_q <= '0;
            tcp_q   <= '0;
        end else begin
            en_q    <= en_d;
            keep_q  <= keep_d;
            tc_q    <= tc_d;
            busy_q  <= busy_d;
            start_q <= start_d;
            abort_q <= abort_d;
            tcp_q   <= tcp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_xfer_start = start_q;
    assign o_xfer_abort = abort_q;
    assign o_busy       = busy_q;
    // one low cycle for each cycle in which a selected channel reaches terminal count
    assign o_combined_terminal_count_out_n = ~|(tcp_q & sel_q);

    ////////////////////////////////////////////////////////////////////////////
    // read data
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // abort and trigger bits are never stored, so they read as zero
    function automatic logic [DATA_W-1:0] ctrl_byte(input logic tc, input logic keep,
                                                    input logic en);
        ctrl_byte           = READ_ZERO;
        ctrl_byte[BIT_TC]   = tc;
        ctrl_byte[BIT_KEEP] = keep;
        ctrl_byte[BIT_EN]   = en;
    endfunction : ctrl_byte

    always_comb begin
        rdata_d = READ_ZERO;
        for (int c = 0; c < N; c++) begin
            if (rd_ctrl[c]) begin
                rdata_d = ctrl_byte(tc_q[c], keep_q[c], en_q[c]);
            end
        end

        if (i_rd) begin
            case (i_addr)
                ADDR_SNAPSHOT: begin
                    rdata_d[N-1:0] = snap_q;
                end
                ADDR_RESTART: begin
                    // restart reads back the live enables
                    rdata_d[N-1:0] = en_q;
                end
                ADDR_TC_SEL: begin
                    rdata_d[N-1:0] = sel_q;
                end
                default: begin
                    // control reads are handled above, the rest read zero
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rdata_q <= RESET_VAL;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
endmodule : dcc_channel_ctrl

// File: pkg/dcc_pkg.sv
package dcc_pkg;
    localparam int          NUM_CH        = 4;
    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 8;
    // channel control offsets, one every two bytes
    localparam logic [31:0] ADDR_CTRL_0   = 32'hffff_f0e0;
    localparam logic [31:0] ADDR_CTRL_1   = 32'hffff_f0e2;
    localparam logic [31:0] ADDR_CTRL_2   = 32'hffff_f0e4;
    localparam logic [31:0] ADDR_CTRL_3   = 32'hffff_f0e6;
    localparam logic [31:0] ADDR_SNAPSHOT = 32'hffff_f0f0;
    localparam logic [31:0] ADDR_RESTART  = 32'hffff_f0f2;
    localparam logic [31:0] ADDR_TC_SEL   = 32'hffff_f0f4;
    // channel control field positions
    localparam int          BIT_TC        = 7;
    localparam int          BIT_KEEP      = 3;
    localparam int          BIT_ABORT     = 2;
    localparam int          BIT_TRIG      = 1;
    localparam int          BIT_EN        = 0;
    localparam logic [7:0]  RESET_VAL     = 8'h00;
    localparam logic [7:0]  READ_ZERO     = 8'h00;
endpackage : dcc_pkg

// File: test/dcc_chk.sv
`timescale 1ns/1ps
module dcc_chk
    import dcc_pkg::*;
#(parameter int N = NUM_CH) (
    input wire logic              i_clock,                        // clock
    input wire logic              i_rst_n,                        // reset
    input wire logic [ADDR_W-1:0] i_addr,                         // address
    input wire logic              i_rd,                           // read
    input wire logic [N-1:0]      i_xfer_done,                    // end
    input wire logic [DATA_W-1:0] o_rdata,                        // data
    input wire logic [N-1:0]      o_xfer_start,                   // start
    input wire logic [N-1:0]      o_xfer_abort,                   // abort
    input wire logic [N-1:0]      o_busy,                         // busy
    input wire logic              o_combined_terminal_count_out_n // tc out
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd(a);
        $past(i_rd) && $past(i_addr) == a;
    endsequence
    a_ctrl_wo_zero: assert property (s_rd(ADDR_CTRL_0) |-> o_rdata[2:1] == 2'h0)
        else $error("write-only bits read back");
    a_snap_high: assert property (s_rd(ADDR_SNAPSHOT) |-> o_rdata[7:4] == 4'h0)
        else $error("snapshot upper bits set");
    a_start_busy: assert property (o_xfer_start[0] |-> o_busy[0])
        else $error("start without busy");
    a_start_single: assert property (o_xfer_start[0] |=> !o_xfer_start[0])
        else $error("start pulse too long");
    a_done_stop: assert property (o_busy[1] && i_xfer_done[1] |=> !o_busy[1])
        else $error("busy after end");
    a_abort_busy: assert property (o_xfer_abort[2] |-> $past(o_busy[2]) && !o_busy[2])
        else $error("abort not terminating");
    a_tco_single: assert property (!o_combined_terminal_count_out_n |=> o_combined_terminal_count_out_n)
        else $error("tc out pulse too long");
    a_tco_cause: assert property (!o_combined_terminal_count_out_n |-> $past(i_xfer_done) != '0)
        else $error("tc out without end");
endmodule : dcc_chk
bind dcc_channel_ctrl dcc_chk #(.N(N)) dcc_chk_i (.i_clock, .i_rst_n, .i_addr, .i_rd,
    .i_xfer_done, .o_rdata, .o_xfer_start, .o_xfer_abort, .o_busy,
    .o_combined_terminal_count_out_n);

// File: test/dcc_eng.sv
`timescale 1ns/1ps
module dcc_eng
    import dcc_pkg::*;
(
    input  wire logic              i_clock,      // clock
    input  wire logic [NUM_CH-1:0] i_xfer_start, // start pulses
    input  wire logic [3:0]        i_lat,        // cycles to end, 0 never ends
    output logic      [NUM_CH-1:0] o_xfer_done   // end pulses
);
    int cnt [NUM_CH] = '{default: 0};
    initial o_xfer_done = '0;
    always @(posedge i_clock) begin
        for (int c = 0; c < NUM_CH; c++) begin
            o_xfer_done[c] <= (cnt[c] == 1);
            if (i_xfer_start[c]) cnt[c] <= i_lat;
            else if (cnt[c] > 0) cnt[c] <= cnt[c] - 1;
        end
    end
endmodule : dcc_eng

// File: test/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %0h got %0h", nm, e, g); end end
module testbench
    import dcc_pkg::*;
;
    logic              i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_nmi = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0, o_rdata;
    logic [1:0]        i_external_request_pin = 2'h0;
    logic [NUM_CH-1:0] i_periph_req = 4'h0, i_pin_sel = 4'h8;
    logic [NUM_CH-1:0] i_xfer_done, o_xfer_start, o_xfer_abort, o_busy;
    logic              o_combined_terminal_count_out_n;
    logic [3:0]        lat = 4'h3;
    int                error_cnt = 0, n_compared = 0, tco_cnt = 0, abort_cnt = 0;
    int                scnt [NUM_CH] = '{default: 0};
    logic [31:0]       ad [7] = '{ADDR_CTRL_0, ADDR_CTRL_1, ADDR_CTRL_2, ADDR_CTRL_3,
                                  ADDR_SNAPSHOT, ADDR_RESTART, ADDR_TC_SEL};
    always #10 i_clock = ~i_clock;
    dcc_channel_ctrl dcc_channel_ctrl_i (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_external_request_pin, .i_periph_req, .i_pin_sel, .i_nmi, .i_xfer_done,
        .o_xfer_start, .o_xfer_abort, .o_busy, .o_combined_terminal_count_out_n);
    dcc_eng dcc_eng_i (.i_clock, .i_xfer_start(o_xfer_start), .i_lat(lat),
        .o_xfer_done(i_xfer_done));
    always @(posedge i_clock) begin
        if (o_combined_terminal_count_out_n === 1'b0) tco_cnt++;
        if (o_xfer_abort[2] === 1'b1) abort_cnt++;
        for (int c = 0; c < NUM_CH; c++) if (o_xfer_start[c] === 1'b1) scnt[c]++;
    end
    task automatic end_sim();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [7:0] e, input string nm,
                      input logic [7:0] m = 8'hff);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 `CHK(nm, e, o_rdata & m)
    endtask : rd
    task automatic hreq(input logic [3:0] p, input logic [1:0] x);
        @(posedge i_clock);
        i_periph_req <= p;
        i_external_request_pin <= x;
        repeat (4) @(posedge i_clock);
        i_periph_req <= 4'h0;
        i_external_request_pin <= 2'h0;
    endtask : hreq
    task automatic idle(input int c);
        repeat (2) @(posedge i_clock);
        for (int k = 0; k < 40 && o_busy[c] !== 1'b0; k++) @(posedge i_clock);
        if (o_busy[c] !== 1'b0) begin
            error_cnt++;
            $display("Error busy timeout");
            end_sim();
        end
    endtask : idle
    initial begin
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        foreach (ad[i]) rd(ad[i], 8'h00, "reset");
        wr(ADDR_TC_SEL, 8'h01);
        rd(ADDR_TC_SEL, 8'h01, "tc_sel");
        wr(ADDR_CTRL_0, 8'h01);
        wr(ADDR_CTRL_0, 8'h03);
        idle(0);
        rd(ADDR_CTRL_0, 8'h80, "ctrl0 end");
        rd(ADDR_CTRL_0, 8'h00, "ctrl0 clr");
        `CHK("tco", 1, tco_cnt)
        wr(ADDR_CTRL_1, 8'h09);
        hreq(4'h2, 2'h0);
        idle(1);
        hreq(4'h2, 2'h0);
        idle(1);
        `CHK("hw starts", 2, scnt[1])
        wr(ADDR_CTRL_1, 8'h0b);
        repeat (4) @(posedge i_clock);
        `CHK("trig refused", 2, scnt[1])
        rd(ADDR_CTRL_1, 8'h89, "ctrl1 keep");
        wr(ADDR_CTRL_1, 8'h0b);
        idle(1);
        `CHK("trig taken", 3, scnt[1])
        `CHK("tco sel", 1, tco_cnt)
        lat <= 4'h0;
        wr(ADDR_CTRL_2, 8'h01);
        wr(ADDR_CTRL_2, 8'h03);
        wr(ADDR_CTRL_2, 8'h04);
        idle(2);
        `CHK("abort", 1, abort_cnt)
        rd(ADDR_CTRL_2, 8'h00, "ctrl2 abort", 8'h01);
        lat <= 4'h3;
        wr(ADDR_CTRL_3, 8'h01);
        wr(ADDR_CTRL_0, 8'h01);
        @(posedge i_clock);
        i_nmi <= 1'b1;
        repeat (5) @(posedge i_clock);
        i_nmi <= 1'b0;
        rd(ADDR_SNAPSHOT, 8'h0b, "snapshot");
        wr(ADDR_SNAPSHOT, 8'h00);
        rd(ADDR_SNAPSHOT, 8'h0b, "snap ro");
        rd(ADDR_CTRL_3, 8'h00, "ctrl3 nmi", 8'h01);
        wr(ADDR_RESTART, 8'h08);
        rd(ADDR_CTRL_3, 8'h01, "restart", 8'h01);
        hreq(4'h0, 2'h2);
        idle(3);
        `CHK("pin start", 1, scnt[3])
        rd(ADDR_RESTART, 8'h00, "enables");
        end_sim();
    end
endmodule : testbench
